/* cmp_pkg.sv */
package cmp_pkg;
   localparam logic [11:0] OFF_TASK_BEGIN = 12'h000;
   localparam logic [11:0] OFF_TASK_HALT = 12'h004;
   localparam logic [11:0] OFF_TASK_CAPTURE = 12'h008;
   localparam logic [11:0] OFF_EV_SETTLED = 12'h100;
   localparam logic [11:0] OFF_EV_FALL = 12'h104;
   localparam logic [11:0] OFF_EV_RISE = 12'h108;
   localparam logic [11:0] OFF_EV_ANY = 12'h10c;
   localparam logic [11:0] OFF_AUTO_LINK = 12'h200;
   localparam logic [11:0] OFF_IRQ_EN_SET = 12'h304;
   localparam logic [11:0] OFF_IRQ_EN_CLR = 12'h308;
   localparam logic [11:0] OFF_OUTCOME = 12'h400;
   localparam logic [11:0] OFF_ENABLE = 12'h500;
   localparam logic [11:0] OFF_PIN = 12'h504;
   localparam logic [11:0] OFF_REF = 12'h508;
   localparam logic [11:0] OFF_EXTREF = 12'h50c;
   localparam logic [11:0] OFF_WAKE = 12'h520;
   // Auto link bit positions
   localparam int LNK_SETTLED_CAPTURE = 0;
   localparam int LNK_SETTLED_HALT = 1;
   localparam int LNK_FALL_HALT = 2;
   localparam int LNK_RISE_HALT = 3;
   localparam int LNK_ANY_HALT = 4;
   // Event and irq-enable bit positions
   localparam int EV_SETTLED = 0;
   localparam int EV_FALL = 1;
   localparam int EV_RISE = 2;
   localparam int EV_ANY = 3;
   localparam logic [1:0] WAKE_ANY = 2'h0;
   localparam logic [1:0] WAKE_RISE = 2'h1;
   localparam logic [1:0] WAKE_FALL = 2'h2;
   // Start-up time in ns and derived cycles at 200 MHz
   localparam int STARTUP_NS = 140;
   localparam int CLK_MHZ = 200;
   localparam int STARTUP_CYC = (STARTUP_NS * CLK_MHZ + 999) / 1000;
   localparam logic [4:0] RST_LINK = 5'h00;
   localparam logic [1:0] RST_ENABLE = 2'h0;

   typedef enum logic [1:0] {ST_OFF, ST_STARTING, ST_RUN} run_state_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef struct packed {
      logic [2:0] pin;
      logic [2:0] ref_sel;
      logic ext_ref;
      logic power_up;
   } analog_ctl_t;

   typedef struct packed {
      run_state_t st;
      logic [7:0] cnt;
      logic s1;
      logic s2;
      logic prev;
      logic [3:0] events;
      logic [3:0] irq_en;
      logic [4:0] link;
      logic outcome;
      logic [1:0] enable;
      logic [2:0] pin;
      logic [2:0] ref_sel;
      logic ext_ref;
      logic [1:0] wake_sel;
      logic [31:0] rdata;
      logic irq;
      logic wake;
   } state_t;
endpackage

/* low_power_comparator.sv */
// Function
// - Write to begin task powers up and starts the comparator.
// - Write to halt task stops comparator and crossing events.
// - Write to capture task latches comparator level into outcome.
// - Settled event raised once start-up time elapsed.
// - Fall event raised when input drops below reference.
// - Rise event raised when input goes above reference.
// - Any-crossing event raised with every directional event.
// - Auto link register holds five enables in bits 0-4, reset zero.
// - Link bit 0 makes settled event trigger capture.
// - Link bit 1 makes settled event trigger halt.
// - Link bits 2-4 make fall, rise, any events trigger halt.
// - Irq enable set register: ones enable, zeros ignored.
// - Irq enable clear register: ones disable, zeros ignored.
// - Outcome register bit 0 holds last captured level, reset zero.
// - Enable register two-bit field gates comparator, reset zero.
// - Pin choice three-bit field selects analog inputs zero to seven.
// - Reference field 0-6 selects supply fraction, 7 external.
// - External reference register one bit selects reference pin.
// - Wake config two-bit field, reset zero, selects wake source.
// - Crossing events generated after settled until halt task.
// - Wake signal from rise, fall or any; deep-sleep wake gives no events.
// - Waking from deep sleep returns all registers to reset values.
module low_power_comparator
   import cmp_pkg::*;
#(
   parameter int STARTUP_CYCLES = STARTUP_CYC
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic sleep_wake,
   input wire bus_req_t bus_req,
   output logic [31:0] bus_rdata,
   input wire logic comp_out,
   output analog_ctl_t analog_ctl,
   output logic irq,
   output logic wake_detect_signal
);
   initial begin
      if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 255) begin
         $error("STARTUP_CYCLES out of range");
      end
   end

   state_t q, d;
   logic wr, rd, go_begin, go_halt, go_capture;
   logic edge_rise, edge_fall, settled_now;
   logic [3:0] ev_set;

   assign wr = bus_req.wr;
   assign rd = bus_req.rd;

   // Task strobes and event logic
   always_comb begin
      d = q;
      go_begin = 1'b0;
      go_halt = 1'b0;
      go_capture = 1'b0;
      if (wr && bus_req.addr == OFF_TASK_BEGIN && bus_req.wdata[0]) begin
         go_begin = 1'b1;
      end
      if (wr && bus_req.addr == OFF_TASK_HALT && bus_req.wdata[0]) begin
         go_halt = 1'b1;
      end
      if (wr && bus_req.addr == OFF_TASK_CAPTURE && bus_req.wdata[0]) begin
         go_capture = 1'b1;
      end

      d.s1 = comp_out;
      d.s2 = q.s1;
      d.prev = q.s2;

      settled_now = (q.st == ST_STARTING) && (q.cnt == 8'(STARTUP_CYCLES - 1));
      edge_rise = (q.st == ST_RUN) && q.s2 && !q.prev;
      edge_fall = (q.st == ST_RUN) && !q.s2 && q.prev;
      ev_set = 4'h0;
      ev_set[EV_SETTLED] = settled_now;
      ev_set[EV_FALL] = edge_fall;
      ev_set[EV_RISE] = edge_rise;
      ev_set[EV_ANY] = edge_rise | edge_fall;

      if (settled_now && q.link[LNK_SETTLED_CAPTURE]) begin
         go_capture = 1'b1;
      end
      if (settled_now && q.link[LNK_SETTLED_HALT]) begin
         go_halt = 1'b1;
      end
      if ((edge_fall && q.link[LNK_FALL_HALT]) || (edge_rise && q.link[LNK_RISE_HALT])
          || ((edge_rise | edge_fall) && q.link[LNK_ANY_HALT])) begin
         go_halt = 1'b1;
      end

      // Run state machine, gated by enable
      case (q.st)
         ST_OFF: begin
            if (go_begin && q.enable != 2'h0) begin
               d.st = ST_STARTING;
               d.cnt = 8'h00;
            end
         end
         ST_STARTING: begin
            d.cnt = q.cnt + 8'h01;
            if (settled_now) begin
               d.st = ST_RUN;
            end
         end
         default: begin
         end
      endcase
      if (go_halt || q.enable == 2'h0) begin
         d.st = ST_OFF;
      end

      if (go_capture) begin
         d.outcome = q.s2;
      end

      // Register writes
      if (wr) begin
         if (bus_req.addr == OFF_EV_SETTLED) begin
            d.events[EV_SETTLED] = bus_req.wdata[0];
         end else if (bus_req.addr == OFF_EV_FALL) begin
            d.events[EV_FALL] = bus_req.wdata[0];
         end else if (bus_req.addr == OFF_EV_RISE) begin
            d.events[EV_RISE] = bus_req.wdata[0];
         end else if (bus_req.addr == OFF_EV_ANY) begin
            d.events[EV_ANY] = bus_req.wdata[0];
         end else if (bus_req.addr == OFF_AUTO_LINK) begin
            d.link = bus_req.wdata[4:0];
         end else if (bus_req.addr == OFF_IRQ_EN_SET) begin
            d.irq_en = q.irq_en | bus_req.wdata[3:0];
         end else if (bus_req.addr == OFF_IRQ_EN_CLR) begin
            d.irq_en = q.irq_en & ~bus_req.wdata[3:0];
         end else if (bus_req.addr == OFF_ENABLE) begin
            d.enable = bus_req.wdata[1:0];
         end else if (bus_req.addr == OFF_PIN) begin
            d.pin = bus_req.wdata[2:0];
         end else if (bus_req.addr == OFF_REF) begin
            d.ref_sel = bus_req.wdata[2:0];
         end else if (bus_req.addr == OFF_EXTREF) begin
            d.ext_ref = bus_req.wdata[0];
         end else if (bus_req.addr == OFF_WAKE) begin
            d.wake_sel = bus_req.wdata[1:0];
         end
      end
      d.events = d.events | ev_set;

      // Read data one cycle later
      d.rdata = 32'h0;
      if (rd) begin
         if (bus_req.addr == OFF_EV_SETTLED) begin
            d.rdata[0] = q.events[EV_SETTLED];
         end else if (bus_req.addr == OFF_EV_FALL) begin
            d.rdata[0] = q.events[EV_FALL];
         end else if (bus_req.addr == OFF_EV_RISE) begin
            d.rdata[0] = q.events[EV_RISE];
         end else if (bus_req.addr == OFF_EV_ANY) begin
            d.rdata[0] = q.events[EV_ANY];
         end else if (bus_req.addr == OFF_AUTO_LINK) begin
            d.rdata[4:0] = q.link;
         end else if (bus_req.addr == OFF_IRQ_EN_SET || bus_req.addr == OFF_IRQ_EN_CLR) begin
            d.rdata[3:0] = q.irq_en;
         end else if (bus_req.addr == OFF_OUTCOME) begin
            d.rdata[0] = q.outcome;
         end else if (bus_req.addr == OFF_ENABLE) begin
            d.rdata[1:0] = q.enable;
         end else if (bus_req.addr == OFF_PIN) begin
            d.rdata[2:0] = q.pin;
         end else if (bus_req.addr == OFF_REF) begin
            d.rdata[2:0] = q.ref_sel;
         end else if (bus_req.addr == OFF_EXTREF) begin
            d.rdata[0] = q.ext_ref;
         end else if (bus_req.addr == OFF_WAKE) begin
            d.rdata[1:0] = q.wake_sel;
         end
      end

      d.irq = |(d.events & d.irq_en);
      case (q.wake_sel)
         WAKE_ANY: d.wake = edge_rise | edge_fall;
         WAKE_RISE: d.wake = edge_rise;
         WAKE_FALL: d.wake = edge_fall;
         default: d.wake = 1'b0;
      endcase
   end

   // State register
   always_ff @(posedge clk_sys) begin
      // wake from deep sleep resets all
      if (srst || sleep_wake) begin
         q <= '0;
         q.link <= RST_LINK;
         q.enable <= RST_ENABLE;
         q.st <= ST_OFF;
      end else begin
         q <= d;
      end
   end

   assign bus_rdata = q.rdata;
   assign irq = q.irq;
   assign wake_detect_signal = q.wake;
   assign analog_ctl.pin = q.pin;
   assign analog_ctl.ref_sel = q.ref_sel;
   assign analog_ctl.ext_ref = q.ext_ref;
   assign analog_ctl.power_up = (q.st != ST_OFF);
endmodule

/* cmp_checker.sv */
module cmp_checker
   import cmp_pkg::*;
#(
   parameter int STARTUP_CYCLES = 2
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic sleep_wake,
   input wire bus_req_t bus_req,
   input wire logic [31:0] bus_rdata,
   input wire logic comp_out,
   input wire analog_ctl_t analog_ctl,
   input wire logic irq,
   input wire logic wake_detect_signal
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst || sleep_wake);
   // Register side relations
   property p_outcome;
      bus_req.rd && bus_req.addr == OFF_OUTCOME |=> bus_rdata[31:1] == 31'h0;
   endproperty
   a_outcome: assert property (p_outcome) else $error("outcome upper bits set");
   property p_begin;
      $rose(analog_ctl.power_up) |-> $past(bus_req.wr && bus_req.addr == OFF_TASK_BEGIN);
   endproperty
   a_begin: assert property (p_begin) else $error("power up without begin");
   property p_halt;
      bus_req.wr && bus_req.addr == OFF_TASK_HALT && bus_req.wdata[0] |=> !analog_ctl.power_up;
   endproperty
   a_halt: assert property (p_halt) else $error("halt ignored");
   property p_en_off;
      bus_req.wr && bus_req.addr == OFF_ENABLE && bus_req.wdata[1:0] == 2'h0
         |-> ##2 !analog_ctl.power_up;
   endproperty
   a_en_off: assert property (p_en_off) else $error("runs while disabled");
   property p_irq_clr;
      bus_req.wr && bus_req.addr == OFF_IRQ_EN_CLR && bus_req.wdata[3:0] == 4'hf
         ##1 !(bus_req.wr && bus_req.addr == OFF_IRQ_EN_SET) |-> ##1 !irq;
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("irq after clear");
   property p_pin;
      bus_req.wr && bus_req.addr == OFF_PIN |=> analog_ctl.pin == $past(bus_req.wdata[2:0]);
   endproperty
   a_pin: assert property (p_pin) else $error("pin choice wrong");
   property p_ref;
      bus_req.wr && bus_req.addr == OFF_REF |=> analog_ctl.ref_sel == $past(bus_req.wdata[2:0]);
   endproperty
   a_ref: assert property (p_ref) else $error("reference choice wrong");
   property p_wake_off;
      !analog_ctl.power_up && !$past(analog_ctl.power_up) |-> !wake_detect_signal;
   endproperty
   a_wake_off: assert property (p_wake_off) else $error("wake while stopped");
   c_wake: cover property (wake_detect_signal);
   c_irq: cover property (irq);
   c_run: cover property ($rose(analog_ctl.power_up));
endmodule
bind low_power_comparator cmp_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) cmp_checker_i (
   .clk_sys(clk_sys), .srst(srst), .sleep_wake(sleep_wake), .bus_req(bus_req),
   .bus_rdata(bus_rdata), .comp_out(comp_out), .analog_ctl(analog_ctl), .irq(irq),
   .wake_detect_signal(wake_detect_signal));

/* comp_core_model.sv */
module comp_core_model (
   input wire logic clk_sys,
   input wire logic power_up,
   input wire logic level,
   output logic comp_out
);
   logic float_q = 1'b0;
   // Unpowered output wanders every cycle
   always_ff @(posedge clk_sys) begin
      float_q <= ~float_q;
   end
   assign comp_out = power_up ? level : float_q;
endmodule

/* low_power_comparator_tb_top.sv */
module low_power_comparator_tb_top
   import cmp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_t;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic sleep_wake = 1'b0;
   logic level = 1'b1;
   bus_req_t req = '0;
   logic [31:0] rdata;
   analog_ctl_t actl;
   logic comp_out;
   logic irq;
   logic wake;
   int mismatches = 0;
   int tests_run = 0;
   logic wake_seen = 1'b0;
   row_t rows [8];
   // Short start-up so crossings settle quickly
   low_power_comparator #(.STARTUP_CYCLES(6)) low_power_comparator_i (
      .clk_sys(clk_sys), .srst(srst), .sleep_wake(sleep_wake), .bus_req(req),
      .bus_rdata(rdata), .comp_out(comp_out), .analog_ctl(actl), .irq(irq),
      .wake_detect_signal(wake));
   comp_core_model comp_core_model_i (.clk_sys(clk_sys), .power_up(actl.power_up),
      .level(level), .comp_out(comp_out));
   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Remember any wake pulse, it stands one cycle only
   always @(posedge clk_sys) begin
      if (wake === 1'b1) begin
         wake_seen <= 1'b1;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clk_sys);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clk_sys);
      req.rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask
   task automatic wait_irq(input logic e);
      for (int i = 0; i < 40 && irq !== e; i++) begin
         @(posedge clk_sys);
         #1;
      end
      chk({31'h0, irq}, {31'h0, e});
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Hang guard
   initial begin
      #20000;
      mismatches++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      rows = '{'{OFF_AUTO_LINK, 32'hffffffff, 32'h1f}, '{OFF_PIN, 32'hffffffff, 32'h7},
         '{OFF_REF, 32'hfffffffe, 32'h6}, '{OFF_EXTREF, 32'hffffffff, 32'h1},
         '{OFF_WAKE, 32'hffffffff, 32'h3}, '{OFF_OUTCOME, 32'hffffffff, 32'h0},
         '{12'h600, 32'hffffffff, 32'h0}, '{OFF_ENABLE, 32'hffffffff, 32'h3}};
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      foreach (rows[i]) begin
         rd(rows[i].a, 32'h0);
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      // Deep-sleep wake clears registers
      @(posedge clk_sys);
      sleep_wake <= 1'b1;
      @(posedge clk_sys);
      sleep_wake <= 1'b0;
      rd(OFF_AUTO_LINK, 32'h0);
      rd(OFF_ENABLE, 32'h0);
      // Start with capture link, all interrupts on
      wr(OFF_REF, 32'h7);
      wr(OFF_AUTO_LINK, 32'h1);
      wr(OFF_IRQ_EN_SET, 32'hf);
      wr(OFF_ENABLE, 32'h1);
      wr(OFF_TASK_BEGIN, 32'h1);
      wait_irq(1'b1);
      rd(OFF_EV_SETTLED, 32'h1);
      rd(OFF_OUTCOME, 32'h1);
      wr(OFF_EV_SETTLED, 32'h0);
      wait_irq(1'b0);
      // Falling crossing
      @(posedge clk_sys);
      level <= 1'b0;
      wait_irq(1'b1);
      rd(OFF_EV_FALL, 32'h1);
      rd(OFF_EV_ANY, 32'h1);
      rd(OFF_EV_RISE, 32'h0);
      wr(OFF_TASK_CAPTURE, 32'h1);
      rd(OFF_OUTCOME, 32'h0);
      // Mask all, then only rise
      wr(OFF_IRQ_EN_CLR, 32'hf);
      wait_irq(1'b0);
      wr(OFF_IRQ_EN_SET, 32'h4);
      wr(OFF_AUTO_LINK, 32'h4);
      wr(OFF_EV_FALL, 32'h0);
      @(posedge clk_sys);
      level <= 1'b1;
      wait_irq(1'b1);
      rd(OFF_EV_RISE, 32'h1);
      wr(OFF_EV_RISE, 32'h0);
      wait_irq(1'b0);
      // Fall crossing halts via link
      wr(OFF_IRQ_EN_SET, 32'h2);
      @(posedge clk_sys);
      level <= 1'b0;
      wait_irq(1'b1);
      rd(OFF_EV_FALL, 32'h1);
      chk({31'h0, actl.power_up}, 32'h0);
      chk({31'h0, wake_seen}, 32'h1);
      // Explicit halt after restart
      wr(OFF_TASK_BEGIN, 32'h1);
      #1;
      chk({31'h0, actl.power_up}, 32'h1);
      wr(OFF_TASK_HALT, 32'h1);
      #1;
      chk({31'h0, actl.power_up}, 32'h0);
      report_and_stop();
   end
endmodule
